// [logic/host_port_pkg.sv]
// Purpose: Shared constants and types for the host port mode and status block
// Assumes: 3-bit host address, 8-bit host data, 16-bit core words
// Notes: Byte registers sit in the upper half of the host address space
package host_port_pkg;

  // Host address map
  localparam logic [2:0] CTRL_OFS = 3'h0;
  localparam logic [2:0] STAT_OFS = 3'h2;
  localparam logic [2:0] BYTE_HIGH_OFS = 3'h6;
  localparam logic [2:0] BYTE_LOW_OFS = 3'h7;

  // Address counter
  localparam logic [1:0] CNT_LAST = 2'h3;
  localparam logic DMA_ADDR_TOP = 1'b1;

  // Transfer mode encodings
  typedef enum logic [1:0] {
    MODE_INT = 2'b00,
    MODE_ILLEGAL = 2'b01,
    MODE_DMA16 = 2'b10,
    MODE_DMA8 = 2'b11
  } xfer_mode_t;

  // Acknowledge tracking
  typedef enum logic {
    ACK_IDLE = 1'b0,
    ACK_BUSY = 1'b1
  } ack_state_t;

  // Host side control byte, bit 7 down to bit 0
  typedef struct packed {
    logic init;
    logic xfer_mode_sel_hi;
    logic xfer_mode_sel_lo;
    logic host_to_core_flag_b;
    logic host_to_core_flag_a;
    logic rsvd;
    logic tx_request_enable;
    logic rx_request_enable;
  } host_side_control_t;

  // Host side status byte, bit 7 down to bit 0
  typedef struct packed {
    logic request;
    logic dma;
    logic rsvd;
    logic core_to_host_flag_b;
    logic core_to_host_flag_a;
    logic tx_path_clear;
    logic host_tx_empty;
    logic host_rx_full;
  } host_side_status_t;

  localparam host_side_control_t CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

endpackage

// [logic/dma_addr_counter.sv]
// Purpose: Two-bit register address counter for DMA byte steering
// Assumes: load and step are one-cycle strobes in the ref_clk domain
// Notes: Load wins over step; the last register reloads instead of wrapping
`timescale 1ns/1ps
`default_nettype none
module dma_addr_counter
  import host_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic step,
  input wire logic [1:0] load_value,
  output logic [1:0] count
);

  logic [1:0] count_q;
  logic [1:0] count_d;

  always_comb begin
    count_d = count_q;
    if (load) begin
      count_d = load_value;
    end else if (step) begin
      if (count_q == CNT_LAST) begin
        count_d = load_value; // [R07]
      end else begin
        count_d = count_q + 2'h1; // [R07]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= 2'h0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count = count_q;

endmodule
`default_nettype wire

// [logic/host_port_mode_and_status.sv]
// Purpose: Host side control, transfer mode and status logic of a parallel host port
// Assumes: Host strobes and acknowledge are synchronous to ref_clk
// Notes: Request pin and data enable are active low; vector register lives outside
//
// Contract
// [R01] Only the host changes host-to-core flag b; core sees it; reset clears it.
// [R02] Mode 00 interrupt, 01 illegal, 10 DMA 16-bit, 11 DMA 8-bit.
// [R03] In DMA mode request pin asks transfers; acknowledge pin grants them.
// [R04] In mode 00 enables gate interrupt requests; acknowledge means vector read.
// [R05] DMA direction from enables; core-to-host drives selected byte during acknowledge.
// [R06] DMA address is top bit one plus the two-bit counter from mode.
// [R07] Counter steps per DMA byte, reloading from mode after the low byte.
// [R08] Reset clears both mode bits, giving interrupt mode.
// [R09] Host sets initialise; hardware runs it and clears it; reset clears it.
// [R10] Interrupt-mode initialise zeroes counter and clears enabled channels.
// [R11] DMA-mode initialise loads counter from mode and clears selected channel.
// [R12] Status byte is read-only: request, DMA, zero, flags, ready, empty, full.
// [R13] Receive-full sets on core word move; clears on low read, initialise, reset.
// [R14] Receive-full drives request when enabled; always valid for polling.
// [R15] Transmit-empty sets on move, initialise, reset; clears on low byte write.
// [R16] Transmit-empty drives request when enabled; always valid for polling.
// [R17] Transmitter-ready is transmit-empty and core receive not full; reset sets.
// [R18] Status bits 3 and 4 mirror core flags; reset clears them.
// [R19] Status bit 5 reads zero.
// [R20] Status bit 6 is set when either mode bit is set.
// [R21] Status bit 7 shows the request pin; reset clears it.
// [R22] DMA: receive enable alone outbound, transmit enable alone inbound.
// [R23] Mode 01 counts as DMA for status; transfers not guaranteed.
`timescale 1ns/1ps
`default_nettype none
module host_port_mode_and_status
  import host_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [2:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_data_oe_n,
  output logic host_request_pin_n,
  input wire logic host_ack_pin_n,
  output logic vector_ack,
  input wire logic core_tx_wr,
  input wire logic [15:0] core_tx_data,
  input wire logic core_rx_rd,
  output logic [15:0] core_rx_data,
  output logic core_rx_full,
  output logic core_tx_empty,
  input wire logic core_to_host_flag_a,
  input wire logic core_to_host_flag_b,
  output logic host_to_core_flag_a,
  output logic host_to_core_flag_b,
  output logic dma_active
);

  host_side_control_t ctrl_q;
  host_side_status_t status;
  ack_state_t ack_q;
  logic [7:0] rx_high_q;
  logic [7:0] rx_low_q;
  logic [7:0] tx_high_q;
  logic [7:0] tx_low_q;
  logic [15:0] core_tx_word_q;
  logic [15:0] core_rx_word_q;
  logic host_rx_full_q;
  logic host_tx_empty_q;
  logic core_rx_full_q;
  logic core_tx_empty_q;
  logic flag_a_mirror_q;
  logic flag_b_mirror_q;
  logic dma_q;
  logic req_q;
  logic req_n_q;
  logic vector_ack_q;
  logic [7:0] rdata_q;
  logic oe_n_q;
  logic [1:0] count;
  xfer_mode_t mode;
  logic dma_on;
  logic dir_rx;
  logic dir_tx;
  logic ack_active;
  logic dma_go;
  logic [2:0] acc_addr;
  logic acc_rd;
  logic acc_wr;
  logic init_run;
  logic init_rx;
  logic init_tx;
  logic xfer_to_host;
  logic xfer_to_core;
  logic cnt_load;
  logic req_src;
  logic [7:0] rdata_d;

  assign mode = xfer_mode_t'({ctrl_q.xfer_mode_sel_hi, ctrl_q.xfer_mode_sel_lo});
  assign dma_on = (mode != MODE_INT); // [R02] [R23]
  assign dir_rx = ctrl_q.rx_request_enable & ~ctrl_q.tx_request_enable; // [R22]
  assign dir_tx = ctrl_q.tx_request_enable & ~ctrl_q.rx_request_enable; // [R22]
  assign ack_active = ~host_ack_pin_n;
  // First cycle of each acknowledge in DMA mode moves one byte
  assign dma_go = dma_on & ack_active & (ack_q == ACK_IDLE); // [R03]
  assign acc_addr = dma_go ? {DMA_ADDR_TOP, count} : host_addr; // [R06]
  assign acc_rd = host_rd | (dma_go & dir_rx); // [R05]
  assign acc_wr = host_wr | (dma_go & dir_tx); // [R05]

  assign init_run = ctrl_q.init; // [R09]
  assign init_rx = init_run & ctrl_q.rx_request_enable; // [R10] [R11]
  assign init_tx = init_run & ctrl_q.tx_request_enable; // [R10] [R11]
  assign xfer_to_host = ~core_tx_empty_q & ~host_rx_full_q;
  assign xfer_to_core = ~host_tx_empty_q & ~core_rx_full_q;
  // Word moves re-arm the counter for the active DMA direction
  assign cnt_load = init_run | (dma_on & ((xfer_to_host & dir_rx) | (xfer_to_core & dir_tx)));

  // Interrupt mode: 00 gives zero, DMA: the mode value itself
  dma_addr_counter u_cnt (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .load(cnt_load), // [R10] [R11]
    .step(dma_go & (dir_rx | dir_tx)), // [R07]
    .load_value(mode), // [R06]
    .count(count)
  );

  always_comb begin
    status = '0;
    status.request = req_q; // [R21]
    status.dma = dma_q; // [R20]
    status.rsvd = 1'b0; // [R19]
    status.core_to_host_flag_b = flag_b_mirror_q; // [R18]
    status.core_to_host_flag_a = flag_a_mirror_q; // [R18]
    status.tx_path_clear = host_tx_empty_q & ~core_rx_full_q; // [R17]
    status.host_tx_empty = host_tx_empty_q; // [R16]
    status.host_rx_full = host_rx_full_q; // [R14]
  end

  always_comb begin
    rdata_d = 8'h00;
    case (acc_addr)
      CTRL_OFS: rdata_d = {ctrl_q[7:3], 1'b0, ctrl_q[1:0]};
      STAT_OFS: rdata_d = status; // [R12]
      BYTE_HIGH_OFS: rdata_d = rx_high_q;
      BYTE_LOW_OFS: rdata_d = rx_low_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Host control byte; status has no write path
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RESET; // [R01] [R08] [R09]
    end else begin
      if (init_run) begin
        ctrl_q.init <= 1'b0; // [R09]
      end
      if (host_wr && !dma_go && host_addr == CTRL_OFS) begin
        ctrl_q <= host_wdata; // [R01]
        ctrl_q.rsvd <= 1'b0;
        ctrl_q.init <= host_wdata[7] | (ctrl_q.init & ~init_run); // [R09]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= ACK_IDLE;
    end else begin
      unique case (ack_q)
        ACK_IDLE: if (dma_go) begin
          ack_q <= ACK_BUSY;
        end
        ACK_BUSY: if (!ack_active) begin
          ack_q <= ACK_IDLE;
        end
      endcase
    end
  end

  // Host transmit bytes
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_high_q <= BYTE_RESET;
      tx_low_q <= BYTE_RESET;
    end else if (acc_wr) begin
      if (acc_addr == BYTE_HIGH_OFS) begin
        tx_high_q <= host_wdata;
      end
      if (acc_addr == BYTE_LOW_OFS) begin
        tx_low_q <= host_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      host_tx_empty_q <= 1'b1; // [R15]
    end else begin
      if (acc_wr && acc_addr == BYTE_LOW_OFS) begin
        host_tx_empty_q <= 1'b0; // [R15]
      end
      if (xfer_to_core || init_tx) begin
        host_tx_empty_q <= 1'b1; // [R15]
      end
    end
  end

  // Core receive word
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      core_rx_word_q <= WORD_RESET;
    end else if (xfer_to_core) begin
      core_rx_word_q <= {tx_high_q, tx_low_q};
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      core_rx_full_q <= 1'b0;
    end else begin
      if (core_rx_rd || init_tx) begin
        core_rx_full_q <= 1'b0; // [R10]
      end
      if (xfer_to_core) begin
        core_rx_full_q <= 1'b1;
      end
    end
  end

  // Core transmit word
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      core_tx_word_q <= WORD_RESET;
    end else if (core_tx_wr) begin
      core_tx_word_q <= core_tx_data;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      core_tx_empty_q <= 1'b1;
    end else begin
      if (core_tx_wr) begin
        core_tx_empty_q <= 1'b0;
      end
      if (xfer_to_host || init_rx) begin
        core_tx_empty_q <= 1'b1; // [R10]
      end
    end
  end

  // Host receive bytes
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_high_q <= BYTE_RESET;
      rx_low_q <= BYTE_RESET;
    end else if (xfer_to_host) begin
      rx_high_q <= core_tx_word_q[15:8];
      rx_low_q <= core_tx_word_q[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      host_rx_full_q <= 1'b0; // [R13]
    end else begin
      if ((acc_rd && acc_addr == BYTE_LOW_OFS) || init_rx) begin
        host_rx_full_q <= 1'b0; // [R13]
      end
      if (xfer_to_host) begin
        host_rx_full_q <= 1'b1; // [R13]
      end
    end
  end

  // Flag mirrors and DMA status
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flag_a_mirror_q <= 1'b0;
      flag_b_mirror_q <= 1'b0;
      dma_q <= 1'b0;
    end else begin
      flag_a_mirror_q <= core_to_host_flag_a; // [R18]
      flag_b_mirror_q <= core_to_host_flag_b; // [R18]
      dma_q <= dma_on; // [R20] [R23]
    end
  end

  // Request pin: enabled sources, dropped while a DMA acknowledge is held
  always_comb begin
    req_src = (ctrl_q.rx_request_enable & host_rx_full_q)
      | (ctrl_q.tx_request_enable & host_tx_empty_q); // [R04] [R14] [R16]
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      req_q <= 1'b0; // [R21]
      req_n_q <= 1'b1;
      vector_ack_q <= 1'b0;
    end else begin
      req_q <= req_src & ~(dma_on & ack_active); // [R03] [R21]
      // Pin copy kept in its own flop so the output needs no inverter
      req_n_q <= ~(req_src & ~(dma_on & ack_active)); // [R03] [R21]
      vector_ack_q <= ~dma_on & ack_active & req_q; // [R04]
    end
  end

  // Host read data and bus drive
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= BYTE_RESET;
      oe_n_q <= 1'b1;
    end else begin
      if (acc_rd) begin
        rdata_q <= rdata_d;
      end
      oe_n_q <= ~(host_rd | (dma_on & dir_rx & ack_active)); // [R05]
    end
  end

  assign host_rdata = rdata_q;
  assign host_data_oe_n = oe_n_q;
  assign host_request_pin_n = req_n_q;
  assign vector_ack = vector_ack_q;
  assign core_rx_data = core_rx_word_q;
  assign core_rx_full = core_rx_full_q;
  assign core_tx_empty = core_tx_empty_q;
  assign host_to_core_flag_a = ctrl_q.host_to_core_flag_a;
  assign host_to_core_flag_b = ctrl_q.host_to_core_flag_b; // [R01]
  assign dma_active = dma_q;

endmodule
`default_nettype wire

// [verif/host_port_chk.sv]
// Purpose: Port-level assertions for the host port mode and status block
// Assumes: Host strobes are single-cycle pulses
// Notes: Bound to the top module by the statement after the module
`timescale 1ns/1ps
`default_nettype none
module host_port_chk
  import host_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [2:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic host_data_oe_n,
  input wire logic host_request_pin_n,
  input wire logic host_ack_pin_n,
  input wire logic vector_ack,
  input wire logic core_to_host_flag_a,
  input wire logic core_to_host_flag_b,
  input wire logic core_tx_empty,
  input wire logic dma_active
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_status_rsvd_zero: assert property (host_rd && host_addr == STAT_OFS |=> !host_rdata[5])
    else $error("status bit 5 not zero");
  a_read_drive_bus: assert property (host_rd |=> !host_data_oe_n)
    else $error("read did not drive the bus");
  a_status_req_bit: assert property (host_rd && host_addr == STAT_OFS
    |=> host_rdata[7] == !$past(host_request_pin_n))
    else $error("status bit 7 differs from request pin");
  a_status_dma_bit: assert property (host_rd && host_addr == STAT_OFS |=>
    host_rdata[6] == $past(dma_active))
    else $error("status bit 6 differs from mode");
  a_flag_mirror: assert property (host_rd && host_addr == STAT_OFS |=>
    host_rdata[4:3] == {$past(core_to_host_flag_b, 2), $past(core_to_host_flag_a, 2)})
    else $error("core flags not mirrored");
  a_reset_values: assert property ($rose(nrst) |-> host_request_pin_n && core_tx_empty
    && !dma_active && host_data_oe_n)
    else $error("wrong values out of reset");
  a_ack_drops_req: assert property (dma_active && !host_request_pin_n
    && $fell(host_ack_pin_n) |=> host_request_pin_n)
    else $error("request kept during transfer acknowledge");
  a_vector_needs_ack: assert property (vector_ack |-> !$past(host_ack_pin_n))
    else $error("vector acknowledge without acknowledge pin");
  a_init_self_clear: assert property (host_wr && host_addr == CTRL_OFS && host_wdata[7]
    ##3 host_rd && host_addr == CTRL_OFS |=> !host_rdata[7])
    else $error("initialise bit not cleared");
  c_init: cover property (host_wr && host_addr == CTRL_OFS && host_wdata[7]);
  c_vector: cover property (vector_ack);
  c_dma_ack: cover property (dma_active && $fell(host_ack_pin_n));
endmodule
bind host_port_mode_and_status host_port_chk chk (.ref_clk, .nrst, .host_addr, .host_rd,
  .host_wr, .host_wdata, .host_rdata, .host_data_oe_n, .host_request_pin_n, .host_ack_pin_n,
  .vector_ack, .core_to_host_flag_a, .core_to_host_flag_b, .core_tx_empty, .dma_active);
`default_nettype wire

// [verif/dma_partner.sv]
// Purpose: External DMA controller answering the request pin
// Assumes: One byte per acknowledge, acknowledge held two cycles
// Notes: Optional wait before each acknowledge; data byte changes after use
`timescale 1ns/1ps
`default_nettype none
module dma_partner (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic en,
  input wire logic slow,
  input wire logic req_n,
  input wire logic oe_n,
  input wire logic [7:0] rdata,
  output logic ack_n,
  output logic [7:0] wbyte,
  output logic [15:0] got,
  output logic [15:0] sent
);
  logic [2:0] cnt_q;
  logic [1:0] st_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_n <= 1'b1;
      st_q <= 2'h0;
      cnt_q <= 3'h0;
      got <= 16'h0000;
      sent <= 16'h0000;
      wbyte <= 8'h5a;
    end else begin
      case (st_q)
        2'h0: if (en && !req_n) begin
          cnt_q <= slow ? 3'h5 : 3'h0;
          st_q <= 2'h1;
        end
        2'h1: if (cnt_q == 3'h0) begin
          ack_n <= 1'b0;
          st_q <= 2'h2;
        end else cnt_q <= cnt_q - 3'h1;
        2'h2: st_q <= 2'h3;
        default: begin
          // Release after two held cycles; line then changes
          ack_n <= 1'b1;
          st_q <= 2'h0;
          if (!oe_n) got <= {got[7:0], rdata};
          sent <= {sent[7:0], wbyte};
          wbyte <= 8'($urandom);
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Purpose: Self-checking bench for the host port mode and status block
// Assumes: Host bus pulses one cycle; DMA side played by dma_partner
// Notes: Seeded random words and control bytes
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import host_port_pkg::*;
  logic ref_clk, nrst, host_rd, host_wr, host_data_oe_n, host_request_pin_n, host_ack_pin_n;
  logic vector_ack, core_tx_wr, core_rx_rd, core_rx_full, core_tx_empty, dma_active;
  logic core_to_host_flag_a, core_to_host_flag_b, host_to_core_flag_a, host_to_core_flag_b;
  logic en, slow, sel;
  logic [2:0] host_addr;
  logic [7:0] wd, host_wdata, host_rdata, wbyte, d;
  logic [15:0] core_tx_data, core_rx_data, got, sent, w, r;
  int fail_count, cmp_count, cyc;
  assign host_wdata = sel ? wbyte : wd;
  host_port_mode_and_status dut (.ref_clk, .nrst, .host_addr, .host_rd, .host_wr, .host_wdata,
    .host_rdata, .host_data_oe_n, .host_request_pin_n, .host_ack_pin_n, .vector_ack,
    .core_tx_wr, .core_tx_data, .core_rx_rd, .core_rx_data, .core_rx_full, .core_tx_empty,
    .core_to_host_flag_a, .core_to_host_flag_b, .host_to_core_flag_a, .host_to_core_flag_b,
    .dma_active);
  dma_partner partner (.ref_clk, .nrst, .en, .slow, .req_n(host_request_pin_n),
    .oe_n(host_data_oe_n), .rdata(host_rdata), .ack_n(host_ack_pin_n), .wbyte, .got, .sent);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("Error at %0t: run too long", $time);
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [15:0] stat(input logic dm, input logic fb, input logic fa);
    return {9'h000, dm, 1'b0, fb, fa, 3'b110};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic rst();
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    tick(1);
    host_wr = 1'b1;
    host_addr = a;
    wd = v;
    tick(1);
    host_wr = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    tick(1);
    host_rd = 1'b1;
    host_addr = a;
    tick(1);
    host_rd = 1'b0;
    tick(1);
    r = {8'h00, host_rdata};
  endtask
  task automatic ctx(input logic [15:0] v);
    tick(1);
    core_tx_data = v;
    core_tx_wr = 1'b1;
    tick(1);
    core_tx_wr = 1'b0;
  endtask
  initial begin
    {nrst, host_rd, host_wr, core_tx_wr, core_rx_rd, en, slow, sel} = '0;
    {core_to_host_flag_a, core_to_host_flag_b, host_addr, wd, core_tx_data} = '0;
    cyc = 0;
    fail_count = 0;
    cmp_count = 0;
    void'($urandom(32'hc576314e));
    rst();
    rd(STAT_OFS); chk(r, 16'h0006);
    rd(CTRL_OFS); chk(r, 16'h0000);
    rd(3'h1); chk(r, 16'h0000);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom) & 8'h7c;
      if (i < 4) d[6:5] = i[1:0];
      core_to_host_flag_a = 1'($urandom);
      core_to_host_flag_b = 1'($urandom);
      wr(CTRL_OFS, d);
      wr(STAT_OFS, 8'hff);
      rd(CTRL_OFS); chk(r, {8'h00, d & 8'h7b});
      chk({14'h0, host_to_core_flag_b, host_to_core_flag_a}, {14'h0, d[4:3]});
      rd(STAT_OFS);
      chk(r, stat(d[6:5] != 2'b00, core_to_host_flag_b, core_to_host_flag_a));
    end
    {core_to_host_flag_a, core_to_host_flag_b} = '0;
    $display("mode and flag test done");
    wr(CTRL_OFS, 8'h01);
    w = 16'($urandom);
    ctx(w);
    tick(3);
    chk({15'h0, host_request_pin_n}, 16'h0000);
    rd(STAT_OFS); chk(r, 16'h0087);
    en = 1'b1;
    tick(10);
    en = 1'b0;
    tick(8);
    rd(BYTE_HIGH_OFS); chk(r, {8'h00, w[15:8]});
    rd(BYTE_LOW_OFS); chk(r, {8'h00, w[7:0]});
    rd(STAT_OFS); chk(r, 16'h0006);
    $display("receive interrupt test done");
    wr(CTRL_OFS, 8'h02);
    tick(2);
    chk({15'h0, host_request_pin_n}, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      wr(BYTE_HIGH_OFS, d);
      wr(BYTE_LOW_OFS, ~d);
      tick(3);
      if (i == 0) chk(core_rx_data, {d, ~d});
      if (i == 0) rd(STAT_OFS);
      if (i == 0) chk(r, 16'h0082);
      if (i == 1) rd(STAT_OFS);
      if (i == 1) chk(r, 16'h0000);
      if (i == 1) core_rx_rd = 1'b1;
      tick(1);
      core_rx_rd = 1'b0;
      tick(3);
      if (i == 1) chk(core_rx_data, {d, ~d});
    end
    wr(CTRL_OFS, 8'h82);
    tick(1);
    rd(CTRL_OFS); chk(r, 16'h0002);
    chk({15'h0, core_rx_full}, 16'h0000);
    rd(STAT_OFS); chk(r, 16'h0086);
    $display("transmit interrupt test done");
    rst();
    wr(CTRL_OFS, 8'hc1);
    en = 1'b1;
    for (int k = 0; k < 2; k++) begin
      slow = k[0];
      w = 16'($urandom);
      ctx(w);
      tick(40);
      chk(got, w);
    end
    rd(STAT_OFS); chk(r & 16'h0040, 16'h0040);
    rst();
    wr(CTRL_OFS, 8'he1);
    w = 16'($urandom);
    ctx(w);
    tick(40);
    chk(got, {8'h00, w[7:0]});
    $display("outbound transfer test done");
    rst();
    wr(CTRL_OFS, 8'hc2);
    sel = 1'b1;
    en = 1'b1;
    for (int i = 0; i < 80 && core_rx_full !== 1'b1; i++) tick(1);
    chk(core_rx_data, sent);
    en = 1'b0;
    sel = 1'b0;
    rst();
    $display("inbound transfer test done");
    end_of_test();
  end
endmodule
`default_nettype wire
